// *** apcd_frac_div.sv ***
`timescale 1ns/1ps
module apcd_frac_div #(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         enable,
  input  wire logic [W-1:0] ratio2,
  output logic              tick,
  output logic              level
);

  initial begin
    if (W < 2) begin
      $error("apcd_frac_div: W too small");
    end
  end

  logic [W-1:0] acc_reg;
  logic [W-1:0] acc_next;
  logic         tick_reg;
  logic         tick_next;
  logic         level_reg;
  logic         level_next;
  logic [W:0]   sum;

  ////////////////////////////////////////////////////////////////////////////
  // Half-step accumulator: with odd ratio2, periods of adjacent lengths alternate
  always_comb begin
    sum        = {1'b0, acc_reg} + (W+1)'(2);
    acc_next   = acc_reg;
    tick_next  = 1'b0;
    level_next = 1'b0;
    if (enable) begin
      if (acc_reg >= ratio2) begin
        // Ratio lowered mid-phase; restart
        acc_next  = '0;
        tick_next = 1'b1;
      end else if (sum >= {1'b0, ratio2}) begin // R19
        acc_next  = W'(sum - {1'b0, ratio2});
        tick_next = 1'b1;
      end else begin
        acc_next = W'(sum);
      end
      level_next = ({1'b0, acc_next} << 1) < {1'b0, ratio2};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_reg   <= '0;
      tick_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      acc_reg   <= acc_next;
      tick_reg  <= tick_next;
      level_reg <= level_next;
    end
  end

  assign tick  = tick_reg;
  assign level = level_reg;

endmodule // apcd_frac_div

// *** apcd_host_port.sv ***
`timescale 1ns/1ps
module apcd_host_port (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic enable,
  output logic      bit_clock,
  output logic      frame,
  output logic      adc_frame
);
  logic [1:0] div_reg;
  logic [3:0] bit_reg;
  // Bit clock of 6 cycles; frames of 8 and 4 bit clocks per phase
  always_ff @(posedge clk) begin
    if (srst || !enable) begin
      div_reg   <= 2'h0;
      bit_reg   <= 4'h0;
      bit_clock <= 1'b0;
      frame     <= 1'b0;
      adc_frame <= 1'b0;
    end else begin
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      if (div_reg == 2'h2) begin
        bit_clock <= !bit_clock;
        if (!bit_clock) begin
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg[2:0] == 3'h7) frame <= !frame;
          if (bit_reg[1:0] == 2'h3) adc_frame <= !adc_frame;
        end
      end
    end
  end
endmodule // apcd_host_port

// *** apcd_pkg.sv ***
package apcd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_MANAGE_FOUR = 8'h0b;
  localparam logic [7:0] IDX_CLOCK_CONTROL_ONE = 8'h28;
  localparam logic [7:0] IDX_CLOCK_CONTROL_TWO = 8'h29;
  localparam logic [7:0] IDX_DAC_FRAME_RATE    = 8'h35;
  localparam logic [7:0] IDX_ADC_FRAME_RATE    = 8'h46;
  localparam logic [7:0] IDX_AUDIO_IF_CONTROL  = 8'h73;
  localparam logic [7:0] IDX_PIN_FUNCTION      = 8'h74;
  localparam logic [7:0] IDX_CLOCK_STATUS      = 8'h75;

  // Field positions
  localparam int POS_SLOW_ENABLE_PM4   = 8;
  localparam int POS_SLOW_ENABLE_CC1   = 15;
  localparam int POS_SLOW_RATE         = 14;
  localparam int POS_BCLK_DIV_LO       = 4;
  localparam int POS_AUX_DIV_LO        = 0;
  localparam int POS_PIN_SOURCE_SELECT = 15;
  localparam int POS_FRAME_GEN_ENABLE  = 11;
  localparam int POS_FRAME_DIV_LO      = 0;
  localparam int POS_BIT_CLOCK_MASTER  = 14;
  localparam int POS_AUX_PIN_ENABLE    = 0;
  localparam int POS_ADC_PIN_ENABLE    = 1;

  // Reset values
  localparam logic [10:0] RST_FRAME_DIVISOR = 11'h040;
  localparam logic [3:0]  RST_BCLK_DIV      = 4'h0;
  localparam logic [2:0]  RST_AUX_DIV       = 3'h0;

  // Timing
  localparam logic [10:0] MIN_FRAME_DIVISOR = 11'h008;
  localparam int          SLOW_DIV_SLOWER   = 2097152;
  localparam int          SLOW_DIV_FASTER   = 524288;

  typedef struct packed {
    logic        slow_tick_enable;
    logic        slow_tick_rate;
    logic [3:0]  bit_clock_divisor;
    logic [2:0]  aux_out_clock_divisor;
    logic        frame_pin_source_select;
    logic        adc_frame_gen_enable;
    logic        dac_frame_gen_enable;
    logic [10:0] adc_frame_divisor;
    logic [10:0] dac_frame_divisor;
    logic        bit_clock_master;
    logic        aux_clock_pin_enable;
    logic        adc_frame_pin_enable;
  } apcd_cfg_t;

  localparam apcd_cfg_t CFG_RESET = '{
    slow_tick_enable:        1'b0,
    slow_tick_rate:          1'b0,
    bit_clock_divisor:       RST_BCLK_DIV,
    aux_out_clock_divisor:   RST_AUX_DIV,
    frame_pin_source_select: 1'b0,
    adc_frame_gen_enable:    1'b0,
    dac_frame_gen_enable:    1'b0,
    adc_frame_divisor:       RST_FRAME_DIVISOR,
    dac_frame_divisor:       RST_FRAME_DIVISOR,
    bit_clock_master:        1'b0,
    aux_clock_pin_enable:    1'b0,
    adc_frame_pin_enable:    1'b0
  };

  // Divide ratios in half steps, so 1.5 and 5.5 stay exact
  function automatic logic [6:0] bclk_ratio2(input logic [3:0] code);
    logic [6:0] r;
    unique case (code)
      4'h0:    r = 7'h02;
      4'h1:    r = 7'h03;
      4'h2:    r = 7'h04;
      4'h3:    r = 7'h06;
      4'h4:    r = 7'h08;
      4'h5:    r = 7'h0b;
      4'h6:    r = 7'h0c;
      4'h7:    r = 7'h10;
      4'h8:    r = 7'h16;
      4'h9:    r = 7'h18;
      4'ha:    r = 7'h20;
      4'hb:    r = 7'h2c;
      4'hc:    r = 7'h30;
      default: r = 7'h40;
    endcase
    return r;
  endfunction

  function automatic logic [6:0] aux_ratio2(input logic [2:0] code);
    logic [6:0] r;
    unique case (code)
      3'h1:    r = 7'h04;
      3'h2:    r = 7'h06;
      3'h3:    r = 7'h08;
      3'h4:    r = 7'h0b;
      3'h5:    r = 7'h0c;
      default: r = 7'h02;
    endcase
    return r;
  endfunction

endpackage

// *** apcd_top.sv ***
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
// How it works
// R1: Master mode divides bit clock into frames
// R2: Bit clock divided from system clock
// R3: Slave mode frame clocks come from outside
// R4: Shared frame pin; separate ADC pin optional
// R5: Select bit routes DAC or ADC frame
// R6: ADC frame generation enable, resets zero
// R7: DAC frame generation enable, resets zero
// R8: Eleven-bit frame divisor, resets to 64
// R9: Divisors below eight invalid, clamped here
// R10: Aux pin drives divided system clock
// R11: Aux divisor 1,2,3,4,5.5,6; reserved codes
// R12: Slow tick enable starts and stops
// R13: Slow enable shared at two addresses
// R14: Rate bit picks 2^21 or 2^19
// R15: Slow tick feeds debounce and timeouts
// R16: Bit clock divisor table, codes to 32
// R17: Bit clock master drives pin
// R18: Frame toggles after divisor bit clocks
// R19: Fractional ratios alternate period lengths
module apcd_top #(
  parameter int SLOW_DIV_SLOWER = apcd_pkg::SLOW_DIV_SLOWER,
  parameter int SLOW_DIV_FASTER = apcd_pkg::SLOW_DIV_FASTER
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        BIT_CLOCK_IN,
  output logic             BIT_CLOCK_OUT,
  output logic             BIT_CLOCK_OE,
  input  wire logic        FRAME_PIN_IN,
  output logic             FRAME_PIN_OUT,
  output logic             FRAME_PIN_OE,
  input  wire logic        ADC_FRAME_PIN_IN,
  output logic             ADC_FRAME_PIN_OUT,
  output logic             ADC_FRAME_PIN_OE,
  output logic             AUX_CLOCK_PIN_OUT,
  output logic             AUX_CLOCK_PIN_OE,
  output logic             ADC_FRAME_CLOCK,
  output logic             DAC_FRAME_CLOCK,
  output logic             BIT_CLOCK_TICK,
  output logic             SLOW_TICK
);

  localparam int SW = $clog2(SLOW_DIV_SLOWER);

  initial begin
    if (SLOW_DIV_FASTER < 2 || SLOW_DIV_SLOWER < SLOW_DIV_FASTER) begin
      $error("apcd_top: slow tick divisors out of range");
    end
  end

  apcd_pkg::apcd_cfg_t cfg_reg;
  apcd_pkg::apcd_cfg_t cfg_next;
  logic                done_reg;
  logic                done_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic [7:0]          index;
  logic                request;
  logic                accept;
  logic [15:0]         read_word;
  logic [15:0]         merged;
  logic                bclk_gen_tick;
  logic                bclk_gen_level;
  logic                aux_level;
  logic                bclk_in_prev_reg;
  logic                bclk_tick;
  logic [1:0]          gen_enable;
  logic [1:0]          frame_gen;
  logic [1:0]          frame_eff;
  logic                adc_pin_source;
  logic [SW-1:0]       slow_cnt_reg;
  logic [SW-1:0]       slow_cnt_next;
  logic                slow_tick_reg;
  logic                slow_tick_next;
  logic [SW-1:0]       slow_last;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer
  assign index           = AVS_ADDRESS[9:2];
  assign request         = AVS_READ | AVS_WRITE;
  assign accept          = request & done_reg;
  assign AVS_WAITREQUEST = request & ~done_reg;
  assign AVS_READDATA    = rdata_reg;

  always_comb begin
    read_word = 16'h0000;
    unique case (index)
      apcd_pkg::IDX_POWER_MANAGE_FOUR: begin
        read_word[apcd_pkg::POS_SLOW_ENABLE_PM4] = cfg_reg.slow_tick_enable;
      end
      apcd_pkg::IDX_CLOCK_CONTROL_ONE: begin
        read_word[apcd_pkg::POS_SLOW_ENABLE_CC1] = cfg_reg.slow_tick_enable;
        read_word[apcd_pkg::POS_SLOW_RATE] = cfg_reg.slow_tick_rate;
        read_word[apcd_pkg::POS_BCLK_DIV_LO +: 4] = cfg_reg.bit_clock_divisor;
        read_word[apcd_pkg::POS_AUX_DIV_LO +: 3] =
          cfg_reg.aux_out_clock_divisor;
      end
      apcd_pkg::IDX_CLOCK_CONTROL_TWO: begin
        read_word[apcd_pkg::POS_PIN_SOURCE_SELECT] =
          cfg_reg.frame_pin_source_select;
      end
      apcd_pkg::IDX_DAC_FRAME_RATE: begin
        read_word[apcd_pkg::POS_FRAME_GEN_ENABLE] = cfg_reg.dac_frame_gen_enable;
        read_word[apcd_pkg::POS_FRAME_DIV_LO +: 11] = cfg_reg.dac_frame_divisor;
      end
      apcd_pkg::IDX_ADC_FRAME_RATE: begin
        read_word[apcd_pkg::POS_FRAME_GEN_ENABLE] = cfg_reg.adc_frame_gen_enable;
        read_word[apcd_pkg::POS_FRAME_DIV_LO +: 11] = cfg_reg.adc_frame_divisor;
      end
      apcd_pkg::IDX_AUDIO_IF_CONTROL: begin
        read_word[apcd_pkg::POS_BIT_CLOCK_MASTER] = cfg_reg.bit_clock_master;
      end
      apcd_pkg::IDX_PIN_FUNCTION: begin
        read_word[apcd_pkg::POS_AUX_PIN_ENABLE] = cfg_reg.aux_clock_pin_enable;
        read_word[apcd_pkg::POS_ADC_PIN_ENABLE] = cfg_reg.adc_frame_pin_enable;
      end
      apcd_pkg::IDX_CLOCK_STATUS: begin
        read_word[3:0] = {slow_tick_reg, frame_eff, BIT_CLOCK_OUT};
      end
      default: read_word = 16'h0000;
    endcase
  end

  always_comb begin
    merged[7:0]  = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : read_word[7:0];
    merged[15:8] = AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : read_word[15:8];
    done_next    = request & ~done_reg;
    rdata_next   = rdata_reg;
    if (AVS_READ && !done_reg) begin
      rdata_next = {16'h0000, read_word};
    end
    cfg_next = cfg_reg;
    if (AVS_WRITE && accept) begin
      unique case (index)
        apcd_pkg::IDX_POWER_MANAGE_FOUR: begin
          cfg_next.slow_tick_enable =
            merged[apcd_pkg::POS_SLOW_ENABLE_PM4]; // R13
        end
        apcd_pkg::IDX_CLOCK_CONTROL_ONE: begin
          cfg_next.slow_tick_enable =
            merged[apcd_pkg::POS_SLOW_ENABLE_CC1]; // R13
          cfg_next.slow_tick_rate = merged[apcd_pkg::POS_SLOW_RATE];
          cfg_next.bit_clock_divisor = merged[apcd_pkg::POS_BCLK_DIV_LO +: 4];
          cfg_next.aux_out_clock_divisor =
            merged[apcd_pkg::POS_AUX_DIV_LO +: 3];
        end
        apcd_pkg::IDX_CLOCK_CONTROL_TWO: begin
          cfg_next.frame_pin_source_select =
            merged[apcd_pkg::POS_PIN_SOURCE_SELECT];
        end
        apcd_pkg::IDX_DAC_FRAME_RATE: begin
          cfg_next.dac_frame_gen_enable =
            merged[apcd_pkg::POS_FRAME_GEN_ENABLE]; // R7
          cfg_next.dac_frame_divisor =
            merged[apcd_pkg::POS_FRAME_DIV_LO +: 11]; // R8
        end
        apcd_pkg::IDX_ADC_FRAME_RATE: begin
          cfg_next.adc_frame_gen_enable =
            merged[apcd_pkg::POS_FRAME_GEN_ENABLE]; // R6
          cfg_next.adc_frame_divisor =
            merged[apcd_pkg::POS_FRAME_DIV_LO +: 11]; // R8
        end
        apcd_pkg::IDX_AUDIO_IF_CONTROL: begin
          cfg_next.bit_clock_master =
            merged[apcd_pkg::POS_BIT_CLOCK_MASTER]; // R17
        end
        apcd_pkg::IDX_PIN_FUNCTION: begin
          cfg_next.aux_clock_pin_enable = merged[apcd_pkg::POS_AUX_PIN_ENABLE];
          cfg_next.adc_frame_pin_enable = merged[apcd_pkg::POS_ADC_PIN_ENABLE];
        end
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_reg   <= apcd_pkg::CFG_RESET; // R5 R6 R7 R8 R12 R14
      done_reg  <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      cfg_reg   <= cfg_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock and auxiliary clock dividers
  apcd_frac_div #(.W(7)) u_bclk_div (
    .clk    (CLK),
    .srst   (SRST),
    .enable (cfg_reg.bit_clock_master),
    .ratio2 (apcd_pkg::bclk_ratio2(cfg_reg.bit_clock_divisor)), // R2 R16
    .tick   (bclk_gen_tick),
    .level  (bclk_gen_level)
  );

  apcd_frac_div #(.W(7)) u_aux_div (
    .clk    (CLK),
    .srst   (SRST),
    .enable (cfg_reg.aux_clock_pin_enable),
    .ratio2 (apcd_pkg::aux_ratio2(cfg_reg.aux_out_clock_divisor)), // R11
    .tick   (),
    .level  (aux_level)
  );

  assign AUX_CLOCK_PIN_OUT = aux_level; // R10
  assign AUX_CLOCK_PIN_OE  = cfg_reg.aux_clock_pin_enable; // R10
  assign BIT_CLOCK_OUT     = bclk_gen_level;
  assign BIT_CLOCK_OE      = cfg_reg.bit_clock_master; // R17

  always_ff @(posedge CLK) begin
    if (SRST) begin
      bclk_in_prev_reg <= 1'b0;
    end else begin
      bclk_in_prev_reg <= BIT_CLOCK_IN;
    end
  end

  // Slave bit clock counted on its rising edges
  assign bclk_tick = cfg_reg.bit_clock_master ? bclk_gen_tick
                   : (BIT_CLOCK_IN & ~bclk_in_prev_reg); // R17
  assign BIT_CLOCK_TICK = bclk_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Frame clock generators, index 0 ADC, 1 DAC
  assign gen_enable = {cfg_reg.dac_frame_gen_enable,
                       cfg_reg.adc_frame_gen_enable};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_frame
      logic [10:0] cnt_reg;
      logic [10:0] cnt_next;
      logic        lvl_reg;
      logic        lvl_next;
      logic [10:0] div_raw;
      logic [10:0] div_eff;

      assign div_raw = (ch == 0) ? cfg_reg.adc_frame_divisor
                                 : cfg_reg.dac_frame_divisor;
      assign div_eff = (div_raw < apcd_pkg::MIN_FRAME_DIVISOR)
                     ? apcd_pkg::MIN_FRAME_DIVISOR : div_raw; // R9

      always_comb begin
        cnt_next = cnt_reg;
        lvl_next = lvl_reg;
        if (!gen_enable[ch]) begin
          cnt_next = 11'h000;
          lvl_next = 1'b0;
        end else if (bclk_tick) begin // R1
          if (cnt_reg + 11'h001 >= div_eff) begin // R18
            cnt_next = 11'h000;
            lvl_next = ~lvl_reg;
          end else begin
            cnt_next = cnt_reg + 11'h001;
          end
        end
      end

      always_ff @(posedge CLK) begin
        if (SRST) begin
          cnt_reg <= 11'h000;
          lvl_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          lvl_reg <= lvl_next;
        end
      end

      assign frame_gen[ch] = lvl_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing; a disabled generator takes its frame from outside
  assign adc_pin_source = cfg_reg.adc_frame_pin_enable ? ADC_FRAME_PIN_IN
                        : FRAME_PIN_IN; // R4
  assign frame_eff[0] = gen_enable[0] ? frame_gen[0] : adc_pin_source; // R3
  assign frame_eff[1] = gen_enable[1] ? frame_gen[1] : FRAME_PIN_IN; // R3

  assign FRAME_PIN_OUT = cfg_reg.frame_pin_source_select
                       ? frame_gen[0] : frame_gen[1]; // R5
  assign FRAME_PIN_OE  = cfg_reg.frame_pin_source_select
                       ? gen_enable[0] : gen_enable[1]; // R5
  assign ADC_FRAME_PIN_OUT = frame_gen[0];
  assign ADC_FRAME_PIN_OE  = cfg_reg.adc_frame_pin_enable
                           & gen_enable[0]; // R4
  assign ADC_FRAME_CLOCK   = frame_eff[0];
  assign DAC_FRAME_CLOCK   = frame_eff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Slow tick for jack debounce and zero-cross timeout
  assign slow_last = cfg_reg.slow_tick_rate
                   ? SW'(SLOW_DIV_FASTER - 1)
                   : SW'(SLOW_DIV_SLOWER - 1); // R14

  always_comb begin
    slow_cnt_next  = '0;
    slow_tick_next = 1'b0;
    if (cfg_reg.slow_tick_enable) begin // R12
      if (slow_cnt_reg >= slow_last) begin
        slow_tick_next = 1'b1;
      end else begin
        slow_cnt_next = slow_cnt_reg + SW'(1);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      slow_cnt_reg  <= '0;
      slow_tick_reg <= 1'b0;
    end else begin
      slow_cnt_reg  <= slow_cnt_next;
      slow_tick_reg <= slow_tick_next;
    end
  end

  assign SLOW_TICK = slow_tick_reg; // R15

endmodule // apcd_top

// *** apcd_top_asserts.sv ***
`timescale 1ns/1ps
module apcd_top_asserts #(
  parameter int SLOW_DIV_SLOWER = 64,
  parameter int SLOW_DIV_FASTER = 16
) (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        BIT_CLOCK_TICK,
  input wire logic        BIT_CLOCK_OE,
  input wire logic        FRAME_PIN_OUT,
  input wire logic        FRAME_PIN_OE,
  input wire logic        ADC_FRAME_PIN_OUT,
  input wire logic        ADC_FRAME_PIN_OE,
  input wire logic        AUX_CLOCK_PIN_OE,
  input wire logic        ADC_FRAME_CLOCK,
  input wire logic        DAC_FRAME_CLOCK,
  input wire logic        SLOW_TICK
);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last slow tick
  logic [31:0] gap_reg;
  logic [31:0] gap_next;
  logic        seen_reg;
  logic        seen_next;
  always_comb begin
    gap_next  = SLOW_TICK ? 32'h0 : gap_reg + 32'h1;
    seen_next = seen_reg | SLOW_TICK;
    if (SRST) begin
      gap_next  = 32'h0;
      seen_next = 1'b0;
    end
  end
  always_ff @(posedge CLK) begin
    gap_reg  <= gap_next;
    seen_reg <= seen_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  wait_one_cycle_a: assert property ((AVS_READ || AVS_WRITE) &&
    AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("wait not one cycle");
  upper_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST |->
    AVS_READDATA[31:16] == 16'h0000) else $error("upper read bits set");
  reset_quiet_a: assert property ($past(SRST) |-> !BIT_CLOCK_OE &&
    !FRAME_PIN_OE && !ADC_FRAME_PIN_OE && !AUX_CLOCK_PIN_OE && !SLOW_TICK)
    else $error("outputs active after reset");
  adc_pin_track_a: assert property (ADC_FRAME_PIN_OE |->
    ADC_FRAME_CLOCK == ADC_FRAME_PIN_OUT) else $error("adc pin mismatch");
  pin_select_a: assert property (FRAME_PIN_OE |->
    FRAME_PIN_OUT == DAC_FRAME_CLOCK || FRAME_PIN_OUT == ADC_FRAME_CLOCK)
    else $error("frame pin source wrong");
  frame_on_tick_a: assert property (ADC_FRAME_PIN_OE &&
    $past(ADC_FRAME_PIN_OE) && $changed(ADC_FRAME_PIN_OUT) |->
    $past(BIT_CLOCK_TICK) || $past(BIT_CLOCK_TICK, 2))
    else $error("frame moved off bit tick");
  slow_pulse_a: assert property (SLOW_TICK |=> !SLOW_TICK)
    else $error("slow tick wider than one cycle");
  slow_gap_a: assert property (SLOW_TICK && seen_reg |->
    gap_reg >= 32'(SLOW_DIV_FASTER - 1)) else $error("slow ticks too close");
  cover property (SLOW_TICK);
  cover property ($rose(FRAME_PIN_OE));
  cover property ($rose(ADC_FRAME_PIN_OE));
endmodule // apcd_top_asserts

bind apcd_top apcd_top_asserts #(
  .SLOW_DIV_SLOWER(SLOW_DIV_SLOWER),
  .SLOW_DIV_FASTER(SLOW_DIV_FASTER)
) u_chk (
  .CLK(CLK), .SRST(SRST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .BIT_CLOCK_TICK(BIT_CLOCK_TICK), .BIT_CLOCK_OE(BIT_CLOCK_OE),
  .FRAME_PIN_OUT(FRAME_PIN_OUT), .FRAME_PIN_OE(FRAME_PIN_OE),
  .ADC_FRAME_PIN_OUT(ADC_FRAME_PIN_OUT), .ADC_FRAME_PIN_OE(ADC_FRAME_PIN_OE),
  .AUX_CLOCK_PIN_OE(AUX_CLOCK_PIN_OE), .ADC_FRAME_CLOCK(ADC_FRAME_CLOCK),
  .DAC_FRAME_CLOCK(DAC_FRAME_CLOCK), .SLOW_TICK(SLOW_TICK)
);

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        CLK, SRST, AVS_READ, AVS_WRITE, host_en;
  logic [9:0]  AVS_ADDRESS;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic        AVS_WAITREQUEST, bclk_in, frame_in, adc_in;
  logic        bclk_out, bclk_oe, fr_out, fr_oe, afr_out, afr_oe;
  logic        aux_out, aux_oe, adc_fc, dac_fc, bclk_tick, slow_tick;
  logic [15:0] q;
  int          failures, comparisons, cyc;
  int          bclk2 [16] = '{2,3,4,6,8,11,12,16,22,24,32,44,48,64,64,64};
  int          aux2 [6] = '{0,4,6,8,11,12};

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  apcd_top #(.SLOW_DIV_SLOWER(64), .SLOW_DIV_FASTER(16)) i_dut (
    .CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .BIT_CLOCK_IN(bclk_in),
    .BIT_CLOCK_OUT(bclk_out), .BIT_CLOCK_OE(bclk_oe),
    .FRAME_PIN_IN(frame_in), .FRAME_PIN_OUT(fr_out), .FRAME_PIN_OE(fr_oe),
    .ADC_FRAME_PIN_IN(adc_in), .ADC_FRAME_PIN_OUT(afr_out),
    .ADC_FRAME_PIN_OE(afr_oe), .AUX_CLOCK_PIN_OUT(aux_out),
    .AUX_CLOCK_PIN_OE(aux_oe), .ADC_FRAME_CLOCK(adc_fc),
    .DAC_FRAME_CLOCK(dac_fc), .BIT_CLOCK_TICK(bclk_tick),
    .SLOW_TICK(slow_tick)
  );

  apcd_host_port i_host (.clk(CLK), .srst(SRST), .enable(host_en),
    .bit_clock(bclk_in), .frame(frame_in), .adc_frame(adc_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic hang;
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [15:0] d);
    int n;
    AVS_ADDRESS   <= {idx, 2'b00};
    AVS_WRITEDATA <= {16'h0000, d};
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    n = 0;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      n++;
      if (n > 50) hang();
      @(posedge CLK);
    end
    q = AVS_READDATA[15:0];
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    chk(q, exp);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0:       pick = bclk_tick;
      1:       pick = aux_out;
      2:       pick = afr_out;
      3:       pick = fr_out;
      4:       pick = slow_tick;
      5:       pick = dac_fc;
      7:       pick = bclk_out;
      default: pick = adc_fc;
    endcase
  endfunction

  // Cycles spanned by two periods, skipping the first one
  task automatic meas(input int s);
    int   k, n;
    logic p, c;
    cyc = 0;
    k = 0;
    n = 0;
    p = pick(s);
    while (k < 4) begin
      @(negedge CLK);
      c = pick(s);
      if (k >= 2) cyc++;
      if (c === 1'b1 && (s == 0 || s == 4 || p !== 1'b1)) k++;
      p = c;
      n++;
      if (n > 3000) hang();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    SRST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 10'h000;
    AVS_BYTEENABLE = 4'h3;
    AVS_WRITEDATA = 32'h0;
    host_en = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    rc(8'h46, 16'h0040);
    rc(8'h35, 16'h0040);
    rc(8'h28, 16'h0000);
    rc(8'h29, 16'h0000);
    rc(8'h0b, 16'h0000);
    bus(1'b1, 8'h10, 16'hffff);
    rc(8'h10, 16'h0000);
    $display("reset test done");
    cyc = 0;
    repeat (150) begin
      @(negedge CLK);
      if (slow_tick === 1'b1) cyc++;
    end
    @(posedge CLK);
    chk(cyc, 0);
    bus(1'b1, 8'h0b, 16'h0100);
    rc(8'h28, 16'h8000);
    meas(4);
    chk(cyc, 128);
    bus(1'b1, 8'h28, 16'h0000);
    bus(1'b1, 8'h28, 16'hc000);
    rc(8'h0b, 16'h0100);
    meas(4);
    chk(cyc, 32);
    bus(1'b1, 8'h28, 16'h0000);
    rc(8'h0b, 16'h0000);
    $display("slow tick test done");
    bus(1'b1, 8'h73, 16'h4000);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 8'h28, 16'(i << 4));
      meas(0);
      chk(cyc, bclk2[i]);
    end
    chk(bclk_oe, 1'b1);
    meas(7);
    chk(cyc, 64);
    bus(1'b1, 8'h74, 16'h0001);
    chk(aux_oe, 1'b1);
    for (int i = 1; i < 6; i++) begin
      bus(1'b1, 8'h28, 16'(i));
      meas(1);
      chk(cyc, aux2[i]);
    end
    for (int i = 6; i < 9; i++) begin
      bus(1'b1, 8'h28, 16'(i & 7));
      bus(1'b0, 8'h28, 16'h0000);
      chk(aux_out, 1'b1);
    end
    $display("divider test done");
    bus(1'b1, 8'h28, 16'h0020);
    bus(1'b1, 8'h74, 16'h0003);
    bus(1'b1, 8'h46, 16'h0808);
    bus(1'b1, 8'h35, 16'h0809);
    meas(2);
    chk(cyc, 64);
    meas(3);
    chk(cyc, 72);
    bus(1'b1, 8'h29, 16'h8000);
    meas(3);
    chk(cyc, 64);
    bus(1'b1, 8'h46, 16'h0803);
    meas(2);
    chk(cyc, 64);
    chk({fr_oe, afr_oe}, 2'b11);
    bus(1'b1, 8'h46, 16'h0008);
    @(posedge CLK);
    chk({afr_oe, afr_out}, 2'b00);
    $display("frame test done");
    bus(1'b1, 8'h35, 16'h0040);
    bus(1'b1, 8'h73, 16'h0000);
    host_en <= 1'b1;
    meas(0);
    chk(cyc, 12);
    meas(5);
    chk(cyc, 192);
    meas(6);
    chk(cyc, 96);
    chk({bclk_oe, fr_oe}, 2'b00);
    $display("slave test done");
    conclude();
  end
endmodule // tb
